// File: inc/fspc_pkg.sv
// Package of constants and types for the flash self-program control block
package fspc_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] FSPC_OFF_CONTROL = 4'h0;
   localparam logic [3:0] FSPC_OFF_KEY = 4'h4;
   localparam logic [3:0] FSPC_OFF_PAGE = 4'h8;
   localparam logic [3:0] FSPC_OFF_TARGET = 4'hC;

   // ---------------------------------------------------------------
   // Control register field positions
   // ---------------------------------------------------------------
   localparam int FSPC_BIT_START = 15;
   localparam int FSPC_BIT_PROG_EN = 14;
   localparam int FSPC_BIT_SEQ_ERR = 13;
   localparam int FSPC_BIT_ERASE = 6;
   localparam int FSPC_OPSEL_LSB = 0;
   localparam int FSPC_OPSEL_W = 4;
   localparam int FSPC_PAGE_W = 8;
   localparam int FSPC_EA_W = 16;
   localparam int FSPC_ADDR_W = 24;

   // ---------------------------------------------------------------
   // Reset values and key values
   // ---------------------------------------------------------------
   localparam logic [15:0] FSPC_CONTROL_RST = 16'h0000;
   localparam logic [7:0] FSPC_PAGE_RST = 8'h00;
   localparam logic [15:0] FSPC_EA_RST = 16'h0000;
   localparam logic [7:0] FSPC_KEY_FIRST = 8'h55;
   localparam logic [7:0] FSPC_KEY_SECOND = 8'hAA;

   // ---------------------------------------------------------------
   // Operation select encodings
   // ---------------------------------------------------------------
   localparam logic [3:0] FSPC_OP_BULK = 4'hF;
   localparam logic [3:0] FSPC_OP_SEGMENT = 4'hD;
   localparam logic [3:0] FSPC_OP_WORD = 4'h3;
   localparam logic [3:0] FSPC_OP_PAGE = 4'h2;
   localparam logic [3:0] FSPC_OP_ROW = 4'h1;
   localparam logic [3:0] FSPC_OP_CONFIG = 4'h0;

   // ---------------------------------------------------------------
   // Timing: nominal self-timed cycle length
   // ---------------------------------------------------------------
   localparam int FSPC_CLK_NS = 40;
   localparam int FSPC_T_CYCLE_NS = 1_430_000;
   localparam int FSPC_CYCLE_CLKS = FSPC_T_CYCLE_NS / FSPC_CLK_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      FSPC_ACT_NONE = 8'b0000_0001,
      FSPC_ACT_BULK_ERASE = 8'b0000_0010,
      FSPC_ACT_SEG_ERASE = 8'b0000_0100,
      FSPC_ACT_PAGE_ERASE = 8'b0000_1000,
      FSPC_ACT_CFG_ERASE = 8'b0001_0000,
      FSPC_ACT_WORD_PROG = 8'b0010_0000,
      FSPC_ACT_ROW_PROG = 8'b0100_0000,
      FSPC_ACT_CFG_PROG = 8'b1000_0000
   } fspc_action_t;

   typedef enum logic [1:0] {
      FSPC_ST_IDLE = 2'b01,
      FSPC_ST_BUSY = 2'b10
   } fspc_state_t;

   typedef enum logic [2:0] {
      FSPC_LK_LOCKED = 3'b001,
      FSPC_LK_HALF = 3'b010,
      FSPC_LK_OPEN = 3'b100
   } fspc_lock_t;

   typedef struct packed {
      logic start;
      logic prog_en;
      logic seq_err;
      logic erase;
      logic [FSPC_OPSEL_W-1:0] op_sel;
   } fspc_ctrl_t;

   typedef struct packed {
      fspc_action_t action;
      logic [FSPC_ADDR_W-1:0] addr;
   } fspc_cmd_t;

endpackage

// File: design/fspc_top.sv
// Flash self-program control: AXI4-Lite registers, unlock key, self-timed cycle
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
//
// Overview of operation
// - Setting start launches a self-timed cycle; hardware clears start when done.
// - Software can only set start; writing zero never clears it.
// - Program enable 1 permits program/erase; 0 inhibits them.
// - Sequence error flag set on improper start attempt or early termination.
// - Erase select 1 chooses erase variant, 0 the program variant.
// - Erase codes: 1111 bulk, 1101 segment, 0010 page, 0000 config; 0011/0001 nothing.
// - Program codes: 0011 word, 0001 row, 0000 config; 1111/1101/0010 nothing.
// - Unlisted operation codes cause no program or erase activity.
// - Control fields reset to zero, only by power-on reset.
// - Control bits 12..7 and 5..4 read as zero.
// - Key register takes low-byte writes, is write-only, reads zero.
// - Start needs 0x55 then 0xAA key writes first; hardware enforces it.
// - Processor stalls while a cycle runs, until start clears.
// - Target address is table page low byte joined to 16-bit effective address.
//
module fspc_top
   import fspc_pkg::*;
#(
   parameter int CYCLE_CLKS = FSPC_CYCLE_CLKS
) (
   // Clock and power-on reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // AXI4-Lite write address and data
   input wire logic [3:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   // AXI4-Lite read
   input wire logic [3:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   // Table write strobe from the core
   input wire logic TBL_WRITE_IN,
   input wire logic [15:0] TBL_EA_IN,
   // Early termination from the flash array
   input wire logic ABORT_IN,
   // Flash array command and core stall
   output logic FLASH_LAUNCH_OUT,
   output logic [7:0] FLASH_ACTION_OUT,
   output logic [23:0] FLASH_ADDR_OUT,
   output logic CPU_STALL_OUT
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   if (CYCLE_CLKS < 2) begin : g_bad_cycle
      $error("CYCLE_CLKS must be at least 2");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   fspc_ctrl_t ctrl_reg;
   fspc_ctrl_t ctrl_next;
   fspc_state_t state_reg;
   fspc_state_t state_next;
   fspc_lock_t lock_reg;
   fspc_lock_t lock_next;
   fspc_cmd_t cmd_reg;
   fspc_action_t action;
   logic [FSPC_PAGE_W-1:0] page_reg;
   logic [FSPC_EA_W-1:0] ea_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic launch_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic wr_take;
   logic rd_take;
   logic wr_ctrl;
   logic wr_key;
   logic wr_page;
   logic key_lane;
   logic start_try;
   logic start_ok;
   logic cycle_end;
   logic [15:0] ctrl_word;

   // ---------------------------------------------------------------
   // Bus handshakes
   // ---------------------------------------------------------------
   // Address and data are taken together; simpler than buffering either
   assign wr_take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !bvalid_reg;
   assign S_AXI_AWREADY_OUT = wr_take;
   assign S_AXI_WREADY_OUT = wr_take;
   assign rd_take = S_AXI_ARVALID_IN && !rvalid_reg;
   assign S_AXI_ARREADY_OUT = rd_take;
   assign S_AXI_BVALID_OUT = bvalid_reg;
   assign S_AXI_BRESP_OUT = bresp_reg;
   assign S_AXI_RVALID_OUT = rvalid_reg;
   assign S_AXI_RRESP_OUT = rresp_reg;
   assign S_AXI_RDATA_OUT = rdata_reg;

   // Write decode by register
   assign wr_ctrl = wr_take && (S_AXI_AWADDR_IN == FSPC_OFF_CONTROL);
   assign wr_key = wr_take && (S_AXI_AWADDR_IN == FSPC_OFF_KEY);
   assign wr_page = wr_take && (S_AXI_AWADDR_IN == FSPC_OFF_PAGE);
   assign key_lane = S_AXI_WSTRB_IN[0];

   // Control word as software sees it; unused bits tie low
   assign ctrl_word = {ctrl_reg.start, ctrl_reg.prog_en, ctrl_reg.seq_err, 6'h00,
                       ctrl_reg.erase, 2'b00, ctrl_reg.op_sel};

   // ---------------------------------------------------------------
   // Operation decode from erase select and operation code
   // ---------------------------------------------------------------
   always_comb begin
      action = FSPC_ACT_NONE;
      if (ctrl_reg.erase) begin
         unique case (ctrl_reg.op_sel)
            FSPC_OP_BULK: action = FSPC_ACT_BULK_ERASE;
            FSPC_OP_SEGMENT: action = FSPC_ACT_SEG_ERASE;
            FSPC_OP_PAGE: action = FSPC_ACT_PAGE_ERASE;
            FSPC_OP_CONFIG: action = FSPC_ACT_CFG_ERASE;
            default: action = FSPC_ACT_NONE;
         endcase
      end else begin
         unique case (ctrl_reg.op_sel)
            FSPC_OP_WORD: action = FSPC_ACT_WORD_PROG;
            FSPC_OP_ROW: action = FSPC_ACT_ROW_PROG;
            FSPC_OP_CONFIG: action = FSPC_ACT_CFG_PROG;
            default: action = FSPC_ACT_NONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Start qualification
   // ---------------------------------------------------------------
   // Start attempt = control write with start bit high while idle
   assign start_try = wr_ctrl && S_AXI_WSTRB_IN[1] && S_AXI_WDATA_IN[FSPC_BIT_START]
                      && (state_reg == FSPC_ST_IDLE);
   // Key and enable are checked against their values before this write
   assign start_ok = start_try && (lock_reg == FSPC_LK_OPEN)
                     && ctrl_reg.prog_en;
   assign cycle_end = (state_reg == FSPC_ST_BUSY) && ((cnt_reg == '0) || ABORT_IN);

   // ---------------------------------------------------------------
   // Unlock sequencer
   // ---------------------------------------------------------------
   always_comb begin
      lock_next = lock_reg;
      if (wr_key && key_lane) begin
         if (S_AXI_WDATA_IN[7:0] == FSPC_KEY_FIRST) begin
            lock_next = FSPC_LK_HALF;
         end else if ((S_AXI_WDATA_IN[7:0] == FSPC_KEY_SECOND) && (lock_reg == FSPC_LK_HALF)) begin
            lock_next = FSPC_LK_OPEN;
         end else begin
            lock_next = FSPC_LK_LOCKED;
         end
      end else if (wr_take) begin
         lock_next = FSPC_LK_LOCKED;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         lock_reg <= FSPC_LK_LOCKED;
      end else begin
         lock_reg <= lock_next;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // Fields are frozen while a cycle runs so the active command cannot change
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl && (state_reg == FSPC_ST_IDLE)) begin
         if (S_AXI_WSTRB_IN[1]) begin
            ctrl_next.prog_en = S_AXI_WDATA_IN[FSPC_BIT_PROG_EN];
            ctrl_next.seq_err = S_AXI_WDATA_IN[FSPC_BIT_SEQ_ERR];
         end
         if (S_AXI_WSTRB_IN[0]) begin
            ctrl_next.erase = S_AXI_WDATA_IN[FSPC_BIT_ERASE];
            ctrl_next.op_sel = S_AXI_WDATA_IN[FSPC_OPSEL_LSB +: FSPC_OPSEL_W];
         end
      end
      // Start is settable only; a zero write leaves it alone
      if (start_ok && (action != FSPC_ACT_NONE)) begin
         ctrl_next.start = 1'b1;
         ctrl_next.seq_err = 1'b0;
      end
      if (start_try && !start_ok) begin
         ctrl_next.seq_err = 1'b1;
      end
      if (cycle_end) begin
         ctrl_next.start = 1'b0;
         if (ABORT_IN) begin
            ctrl_next.seq_err = 1'b1;
         end
      end
   end

   // Only the power-on reset returns these fields to zero
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ctrl_reg <= fspc_ctrl_t'({FSPC_CONTROL_RST[15:13], FSPC_CONTROL_RST[6], FSPC_CONTROL_RST[3:0]});
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ---------------------------------------------------------------
   // Table page and latched effective address
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         page_reg <= FSPC_PAGE_RST;
      end else if (wr_page && S_AXI_WSTRB_IN[0] && (state_reg == FSPC_ST_IDLE)) begin
         page_reg <= S_AXI_WDATA_IN[FSPC_PAGE_W-1:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ea_reg <= FSPC_EA_RST;
      end else if (TBL_WRITE_IN && (state_reg == FSPC_ST_IDLE)) begin
         ea_reg <= TBL_EA_IN;
      end
   end

   // ---------------------------------------------------------------
   // Cycle sequencer and timer
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FSPC_ST_IDLE: begin
            if (start_ok && (action != FSPC_ACT_NONE)) begin
               state_next = FSPC_ST_BUSY;
            end
         end
         FSPC_ST_BUSY: begin
            if (cycle_end) begin
               state_next = FSPC_ST_IDLE;
            end
         end
         default: state_next = FSPC_ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state_reg <= FSPC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Self-timed length counted down from launch
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cnt_reg <= '0;
      end else if (state_next == FSPC_ST_BUSY && state_reg == FSPC_ST_IDLE) begin
         cnt_reg <= CNT_W'(CYCLE_CLKS - 1);
      end else if (state_reg == FSPC_ST_BUSY && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // Command captured at launch for the flash array
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cmd_reg <= '{action: FSPC_ACT_NONE, addr: '0};
         launch_reg <= 1'b0;
      end else begin
         launch_reg <= start_ok && (action != FSPC_ACT_NONE);
         if (start_ok && (action != FSPC_ACT_NONE)) begin
            cmd_reg <= '{action: action, addr: {page_reg, ea_reg}};
         end
      end
   end

   assign FLASH_LAUNCH_OUT = launch_reg;
   assign FLASH_ACTION_OUT = cmd_reg.action;
   assign FLASH_ADDR_OUT = cmd_reg.addr;
   assign CPU_STALL_OUT = ctrl_reg.start;

   // ---------------------------------------------------------------
   // Write response
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_take) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (S_AXI_AWADDR_IN[3:2] == FSPC_OFF_TARGET[3:2]) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_BREADY_IN) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read data path
   // ---------------------------------------------------------------
   // Key always reads zero: it is write-only
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         unique case (S_AXI_ARADDR_IN)
            FSPC_OFF_CONTROL: rdata_reg <= {16'h0000, ctrl_word};
            FSPC_OFF_KEY: rdata_reg <= 32'h0000_0000;
            FSPC_OFF_PAGE: rdata_reg <= {24'h00_0000, page_reg};
            FSPC_OFF_TARGET: rdata_reg <= {8'h00, page_reg, ea_reg};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RREADY_IN) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule // fspc_top

// File: design/fspc_fix_note.sv
// No logic here: the whole block lives in fspc_top

// File: testbench/fspc_sva.sv
// Assertion checker for the flash self-program control ports
`timescale 1ns/1ps
module fspc_sva
   import fspc_pkg::*;
#(
   parameter int CYCLE_CLKS = FSPC_CYCLE_CLKS
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Write channels
   input wire logic [3:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   input wire logic S_AXI_BVALID_OUT,
   // Flash side
   input wire logic ABORT_IN,
   input wire logic FLASH_LAUNCH_OUT,
   input wire logic [7:0] FLASH_ACTION_OUT,
   input wire logic CPU_STALL_OUT
);
   // ---------------------------------------------
   // Helper logic
   // ---------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   logic wr_take;
   logic start_wr;
   logic key_half_reg;
   logic key_ok_reg;
   int busy_cnt_reg;
   assign wr_take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
   // Control write that asks for a start
   assign start_wr = wr_take && S_AXI_AWADDR_IN == FSPC_OFF_CONTROL && S_AXI_WDATA_IN[FSPC_BIT_START]
      && S_AXI_WSTRB_IN[1];
   // Any write that is not the next key breaks the unlock
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         key_half_reg <= 1'b0;
         key_ok_reg <= 1'b0;
      end else if (wr_take) begin
         key_half_reg <= S_AXI_AWADDR_IN == FSPC_OFF_KEY && S_AXI_WDATA_IN[7:0] == FSPC_KEY_FIRST;
         key_ok_reg <= key_half_reg && S_AXI_AWADDR_IN == FSPC_OFF_KEY && S_AXI_WDATA_IN[7:0] == FSPC_KEY_SECOND;
      end
   end
   // Busy length, counted by hand to keep repetitions short
   always_ff @(posedge CLK_IN) begin
      if (RST_IN || !CPU_STALL_OUT) busy_cnt_reg <= 0;
      else busy_cnt_reg <= busy_cnt_reg + 1;
   end
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   AST_LAUNCH_CAUSE:
   assert property (FLASH_LAUNCH_OUT |-> $past(start_wr)) else $error("launch without start write");
   AST_UNLOCKED:
   assert property (FLASH_LAUNCH_OUT |-> $past(key_ok_reg)) else $error("launch without unlock");
   AST_LAUNCH_PULSE:
   assert property (FLASH_LAUNCH_OUT |=> !FLASH_LAUNCH_OUT) else $error("launch longer than one cycle");
   AST_STALL_AT_LAUNCH:
   assert property (FLASH_LAUNCH_OUT |-> CPU_STALL_OUT && !$past(CPU_STALL_OUT)) else $error("stall not at launch");
   AST_STALL_CAUSE:
   assert property ($rose(CPU_STALL_OUT) |-> FLASH_LAUNCH_OUT) else $error("stall without launch");
   AST_SELF_TIMED:
   assert property ($fell(CPU_STALL_OUT) && !$past(ABORT_IN) |-> busy_cnt_reg == CYCLE_CLKS)
      else $error("cycle length wrong");
   AST_BUSY_BOUND:
   assert property (busy_cnt_reg <= CYCLE_CLKS) else $error("cycle overran");
   AST_ABORT_ENDS:
   assert property (CPU_STALL_OUT && ABORT_IN |=> !CPU_STALL_OUT) else $error("abort ignored");
   AST_ACTION_VALID:
   assert property (FLASH_LAUNCH_OUT |-> $onehot(FLASH_ACTION_OUT) && FLASH_ACTION_OUT != FSPC_ACT_NONE)
      else $error("launch with no action");
   AST_NO_RELAUNCH:
   assert property ($past(CPU_STALL_OUT) |-> !FLASH_LAUNCH_OUT) else $error("launch while busy");
endmodule // fspc_sva

// File: testbench/fspc_core_model.sv
// Behavioural core model issuing table writes between flash cycles
`timescale 1ns/1ps
module fspc_core_model (
   // Clock, reset and stall
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic stall_in,
   // Request from the bench
   input wire logic req_in,
   input wire logic [15:0] ea_in,
   // Table write to the block
   output logic tbl_write_out,
   output logic [15:0] tbl_ea_out
);
   // A stalled core executes nothing; idle address toggles so no stale value passes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tbl_write_out <= 1'b0;
         tbl_ea_out <= 16'h0000;
      end else begin
         tbl_write_out <= req_in && !stall_in;
         tbl_ea_out <= (req_in && !stall_in) ? ea_in : ~tbl_ea_out;
      end
   end
endmodule // fspc_core_model

// File: testbench/flash_self_program_control_bench.sv
// Self-checking bench for the flash self-program control block
`timescale 1ns/1ps
module flash_self_program_control_bench import fspc_pkg::*;;
   // ---------------------------------------------
   // Signals, design and partner
   // ---------------------------------------------
   localparam int CYC = 24;
   localparam logic [15:0] ROW_F [14] = '{16'h404F, 16'h404D, 16'h4042, 16'h4040, 16'h4043, 16'h4041,
      16'h4003, 16'h4001, 16'h4000, 16'h400F, 16'h400D, 16'h4002, 16'h4047, 16'h4004};
   localparam logic [7:0] ROW_A [14] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h01,
      8'h20, 8'h40, 8'h80, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
   logic clk = 1'b0;
   logic rst, awv, wv, bv, brdy, arv, rv, rrdy, awr, wrd, arr, tbw, req, abort, launch, stall;
   logic [3:0] awa, ara, strb;
   logic [31:0] wd, rdat, rdv;
   logic [1:0] br, rr, resp;
   logic [15:0] ea, tea;
   logic [7:0] act, last_act;
   logic [23:0] faddr;
   int n_fail = 0;
   int n_checks = 0;
   int n_launch = 0;
   always #20 clk = ~clk;
   fspc_top #(.CYCLE_CLKS(CYC)) DUT (.CLK_IN(clk), .RST_IN(rst),
      .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(strb), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(brdy), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rrdy), .TBL_WRITE_IN(tbw), .TBL_EA_IN(tea), .ABORT_IN(abort),
      .FLASH_LAUNCH_OUT(launch), .FLASH_ACTION_OUT(act), .FLASH_ADDR_OUT(faddr), .CPU_STALL_OUT(stall));
   fspc_core_model core (.clk_in(clk), .rst_in(rst), .stall_in(stall), .req_in(req), .ea_in(ea),
      .tbl_write_out(tbw), .tbl_ea_out(tea));
   // Launch monitor
   always @(posedge clk) begin
      if (launch === 1'b1) begin
         n_launch <= n_launch + 1;
         last_act <= act;
      end
   end
   // ---------------------------------------------
   // Bus tasks and checks
   // ---------------------------------------------
   task automatic w(input logic [3:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do @(posedge clk); while (awr !== 1'b1 || wrd !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge clk); while (bv !== 1'b1);
      resp = br;
      brdy <= 1'b0;
      @(posedge clk);
   endtask
   task automatic r(input logic [3:0] a);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rdv = rdat;
      resp = rr;
      rrdy <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      r(a);
      chk({30'h0, resp}, 32'h0, "read resp");
      chk(rdv, e, "read data");
   endtask
   task automatic unlock();
      w(FSPC_OFF_KEY, 32'h55);
      w(FSPC_OFF_KEY, 32'hAA);
   endtask
   task automatic idle();
      for (int i = 0; i < 64 && stall !== 1'b0; i++) @(posedge clk);
      @(posedge clk);
   endtask
   task automatic tend(input string s);
      $display("%0t test %s finished", $time, s);
   endtask
   // Setup, unlock, start; the code decides whether anything launches
   task automatic run_op(input logic [15:0] f, input logic [7:0] e);
      int n0;
      n0 = n_launch;
      w(FSPC_OFF_CONTROL, {16'h0, f});
      unlock();
      w(FSPC_OFF_CONTROL, {16'h0, f | 16'h8000});
      idle();
      chk(32'(n_launch - n0), {31'h0, e != FSPC_ACT_NONE}, "launch count");
      if (e != FSPC_ACT_NONE) chk({24'h0, last_act}, {24'h0, e}, "action");
      rd_chk(FSPC_OFF_CONTROL, {16'h0, f});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      {awv, wv, brdy, arv, rrdy, req, abort} <= '0;
      {awa, ara, wd, ea} <= '0;
      strb <= 4'hF;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(FSPC_OFF_CONTROL, 32'h0);
      r(4'h2);
      chk({30'h0, resp}, 32'h2, "unmapped resp");
      tend("reset");
      for (int i = 0; i < 14; i++) run_op(ROW_F[i], ROW_A[i]);
      tend("table");
      w(FSPC_OFF_KEY, 32'hFFFF_FFFF);
      rd_chk(FSPC_OFF_KEY, 32'h0);
      w(FSPC_OFF_CONTROL, 32'h5FFF);
      rd_chk(FSPC_OFF_CONTROL, 32'h404F);
      w(FSPC_OFF_CONTROL, 32'hC001);
      rd_chk(FSPC_OFF_CONTROL, 32'h6001);
      w(FSPC_OFF_CONTROL, 32'h0001);
      unlock();
      w(FSPC_OFF_CONTROL, 32'h8001);
      rd_chk(FSPC_OFF_CONTROL, 32'h2001);
      w(FSPC_OFF_CONTROL, 32'h4001);
      w(FSPC_OFF_KEY, 32'h55);
      w(FSPC_OFF_PAGE, 32'h0);
      w(FSPC_OFF_KEY, 32'hAA);
      w(FSPC_OFF_CONTROL, 32'hC001);
      rd_chk(FSPC_OFF_CONTROL, 32'h6001);
      tend("refusals");
      w(FSPC_OFF_PAGE, 32'hA5);
      ea <= 16'h1280;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      w(FSPC_OFF_CONTROL, 32'h4001);
      unlock();
      w(FSPC_OFF_CONTROL, 32'hC001);
      chk({8'h0, faddr}, 32'h00A5_1280, "target");
      chk({31'h0, stall}, 32'h1, "stall");
      w(FSPC_OFF_CONTROL, 32'h0);
      rd_chk(FSPC_OFF_CONTROL, 32'hC001);
      idle();
      rd_chk(FSPC_OFF_TARGET, 32'h00A5_1280);
      w(FSPC_OFF_TARGET, 32'h0);
      chk({30'h0, resp}, 32'h2, "target write resp");
      w(FSPC_OFF_CONTROL, 32'hC001);
      rd_chk(FSPC_OFF_CONTROL, 32'h6001);
      tend("busy");
      w(FSPC_OFF_CONTROL, 32'h4001);
      unlock();
      w(FSPC_OFF_CONTROL, 32'hC001);
      abort <= 1'b1;
      @(posedge clk);
      abort <= 1'b0;
      idle();
      rd_chk(FSPC_OFF_CONTROL, 32'h6001);
      w(FSPC_OFF_CONTROL, 32'h4001);
      unlock();
      w(FSPC_OFF_CONTROL, 32'hC001);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({31'h0, stall}, 32'h0, "stall after reset");
      rd_chk(FSPC_OFF_CONTROL, 32'h0);
      tend("abort and reset");
      final_report();
   end
   // Watchdog, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule // flash_self_program_control_bench
bind fspc_top fspc_sva #(.CYCLE_CLKS(CYCLE_CLKS)) u_sva (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .S_AXI_AWADDR_IN(S_AXI_AWADDR_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_WDATA_IN(S_AXI_WDATA_IN),
   .S_AXI_WSTRB_IN(S_AXI_WSTRB_IN), .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
   .ABORT_IN(ABORT_IN), .FLASH_LAUNCH_OUT(FLASH_LAUNCH_OUT), .FLASH_ACTION_OUT(FLASH_ACTION_OUT),
   .CPU_STALL_OUT(CPU_STALL_OUT));
